// >>> spc_pulse_io.sv
// pulse command decoder and status output driver of the servo drive
`timescale 1ns/100ps

// Overview of operation
// - step/direction port decodes pulse trains up to 500kHz; host stays at or below.
// - fast pulse/sign port accepts up to 2MHz; host stays at or below.
// - step with direction active moves one way, inactive the other way.
// - a setting inverts the rotation sense tied to the direction level.
// - pulses on first input move one way, on second input the other.
// - quadrature direction follows the leading phase, mapping configurable.
// - by default, first input leading second gives clockwise rotation.
// - in position mode first two inputs are pulse only; else general inputs.
// - six outputs, each assignable to permitted functions or general use.
// - second output is brake control or general purpose.
// - moving function on fourth output: position mode and following error below threshold.
// - velocity reached: velocity or torque mode, speed equals command and ripple within band.
// - servo ready on fifth output: drive able and no alarm.
// - in position on sixth output: position mode, in position and error below threshold.
// - encoder A, B and index repeated to host; index also open collector.
// - three pulse formats: step/direction, CW/CCW, A/B quadrature.
// - pulse inhibit in position mode ignores pulses, position unchanged.
module spc_pulse_io #(
    parameter int POS_W = 32
) (
    // clock, reset, enable
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    // configuration and drive state
    input wire spc_pkg::spc_cfg_t CFG,
    input wire spc_pkg::spc_stat_t STAT,
    // command pulse pins
    input wire logic FAST_INPUT_ONE,
    input wire logic FAST_INPUT_TWO,
    input wire logic FAST_PULSE_IN,
    input wire logic FAST_SIGN_IN,
    input wire logic PULSE_INHIBIT_INPUT,
    // decoded command toward the position loop
    output logic signed [POS_W-1:0] CMD_POS,
    output logic CMD_STEP,
    output logic CMD_DIR_CW,
    output logic GP_IN_ONE,
    output logic GP_IN_TWO,
    // motor encoder
    input wire logic ENC_A,
    input wire logic ENC_B,
    input wire logic ENC_Z,
    // status outputs
    output logic OUTPUT_ONE,
    output logic OUTPUT_TWO,
    output logic OUTPUT_THREE,
    output logic OUTPUT_FOUR,
    output logic OUTPUT_FIVE,
    output logic OUTPUT_SIX,
    // encoder feedback toward the host
    output logic FEEDBACK_PHASE_A,
    output logic FEEDBACK_PHASE_B,
    output logic FEEDBACK_INDEX,
    output logic FEEDBACK_INDEX_OC_O,
    output logic FEEDBACK_INDEX_OC_OE
);
    import spc_pkg::*;

    // quadrature step: {valid, up}; gray order 00,10,11,01 counts up
    function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] now);
        logic [1:0] res;
        res = 2'h0;
        unique case ({prev, now})
            4'h2, 4'hb, 4'hd, 4'h4: res = 2'h3;
            4'h1, 4'h7, 4'he, 4'h8: res = 2'h2;
            default: res = 2'h0; // no change, or both phases changed
        endcase
        return res;
    endfunction

    // which functions each output may take; anything else falls back to general use
    function automatic logic func_allowed(input int idx, input spc_func_t f);
        logic ok;
        ok = (f == FUNC_GENERAL);
        unique case (idx)
            0: ok = ok | (f == FUNC_ALARM);
            1: ok = ok | (f == FUNC_BRAKE);
            2: ok = ok | (f == FUNC_TORQUE_REACH);
            3: ok = ok | (f == FUNC_MOVING) | (f == FUNC_VEL_REACH);
            4: ok = ok | (f == FUNC_SERVO_READY) | (f == FUNC_SERVO_ON);
            default: ok = ok | (f == FUNC_IN_POS) | (f == FUNC_TACH);
        endcase
        return ok;
    endfunction

    wire [NUM_CH-1:0] raw = {PULSE_INHIBIT_INPUT, FAST_SIGN_IN, FAST_PULSE_IN,
                             FAST_INPUT_TWO, FAST_INPUT_ONE};
    logic [NUM_CH-1:0] flt;

    // two-flop sync then a stability filter per input
    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : g_filt
            localparam logic [7:0] LIM = (g == CH_PULSE || g == CH_SIGN) ?
                                         8'(FAST_FILT_CYC) : 8'(OPTO_FILT_CYC);
            logic s1_r, s2_r, flt_r;
            logic [7:0] cnt_r;
            wire settle = (cnt_r == LIM - 8'h01);
            always_ff @(posedge CORE_CLK or posedge RST)
            begin
                if (RST)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    flt_r <= 1'b0;
                    cnt_r <= 8'h00;
                end
                else if (CE)
                begin
                    s1_r <= raw[g];
                    s2_r <= s1_r;
                    flt_r <= (s2_r != flt_r && settle) ? s2_r : flt_r;
                    cnt_r <= (s2_r == flt_r || settle) ? 8'h00 : cnt_r + 8'h01;
                end
            end
            assign flt[g] = flt_r;
        end
    endgenerate

    // source and edge decoding; the host keeps to one port, the other is not looked at
    wire pos_mode = (CFG.mode == MODE_POSITION);
    wire a_cur = CFG.port_fast ? flt[CH_PULSE] : flt[CH_ONE];
    wire b_cur = CFG.port_fast ? flt[CH_SIGN] : flt[CH_TWO];
    logic a_prev_r, b_prev_r;
    wire rise_a = a_cur & ~a_prev_r;
    wire rise_b = b_cur & ~b_prev_r;
    wire [1:0] qs = quad_step({a_prev_r, b_prev_r}, {a_cur, b_cur});

    // per-format step and direction
    wire sd_valid = rise_a;
    wire sd_up = b_cur ^ CFG.dir_invert;
    wire cc_valid = rise_a ^ rise_b;
    wire cc_up = rise_a ^ CFG.dir_invert;
    wire qd_valid = qs[1];
    wire qd_up = qs[0] ^ CFG.quad_invert;
    wire fmt_valid = (CFG.fmt == FMT_STEP_DIR) ? sd_valid :
                     (CFG.fmt == FMT_CW_CCW) ? cc_valid :
                     (CFG.fmt == FMT_QUAD) ? qd_valid : 1'b0;
    wire fmt_up = (CFG.fmt == FMT_STEP_DIR) ? sd_up :
                  (CFG.fmt == FMT_CW_CCW) ? cc_up : qd_up;
    wire inhibit = flt[CH_INHIBIT] & pos_mode;
    wire cnt_en = fmt_valid & pos_mode & ~inhibit;
    wire signed [POS_W-1:0] pos_nxt = fmt_up ? CMD_POS + POS_W'(1) : CMD_POS - POS_W'(1);

    // command counter; edges are still tracked while inhibited so release adds no step
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            CMD_POS <= '0;
            CMD_STEP <= 1'b0;
            CMD_DIR_CW <= 1'b0;
            GP_IN_ONE <= 1'b0;
            GP_IN_TWO <= 1'b0;
        end
        else if (CE)
        begin
            a_prev_r <= a_cur;
            b_prev_r <= b_cur;
            CMD_POS <= cnt_en ? pos_nxt : CMD_POS;
            CMD_STEP <= cnt_en;
            CMD_DIR_CW <= cnt_en ? fmt_up : CMD_DIR_CW;
            GP_IN_ONE <= flt[CH_ONE] & ~pos_mode;
            GP_IN_TWO <= flt[CH_TWO] & ~pos_mode;
        end
    end

    // encoder repeat and tach divider
    logic [2:0] enc_r;
    logic [15:0] tach_cnt_r;
    logic tach_r;
    wire [1:0] es = quad_step(enc_r[2:1], {ENC_A, ENC_B});
    wire tach_hit = es[1] && ({1'b0, tach_cnt_r} + 17'h00001 >= {1'b0, CFG.tach_div});
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            enc_r <= ENC_RST;
            tach_cnt_r <= 16'h0000;
            tach_r <= 1'b0;
        end
        else if (CE)
        begin
            enc_r <= {ENC_A, ENC_B, ENC_Z};
            tach_cnt_r <= tach_hit ? 16'h0000 : (es[1] ? tach_cnt_r + 16'h0001 : tach_cnt_r);
            tach_r <= tach_r ^ tach_hit;
        end
    end
    assign FEEDBACK_PHASE_A = enc_r[2];
    assign FEEDBACK_PHASE_B = enc_r[1];
    assign FEEDBACK_INDEX = enc_r[0];
    // open collector pulls low while the index is high
    assign FEEDBACK_INDEX_OC_O = 1'b0;
    assign FEEDBACK_INDEX_OC_OE = enc_r[0];

    // status function values, indexed by function code
    wire moving = pos_mode & (STAT.follow_err < CFG.move_thresh);
    wire vel_reach = (CFG.mode == MODE_VELOCITY || CFG.mode == MODE_TORQUE) &
                     (STAT.speed_act == STAT.speed_cmd) &
                     (STAT.ripple <= CFG.ripple_band);
    wire ready = STAT.drive_able & ~STAT.alarm;
    wire in_pos = pos_mode & STAT.in_position & (STAT.pos_err < CFG.inpos_thresh);
    wire [15:0] func_val = {6'h00, tach_r, in_pos, STAT.servo_on, ready, vel_reach,
                            moving, STAT.torque_reached, STAT.brake_on, STAT.alarm, 1'b0};

    // output selection; registered so glitches of the compares never reach a pin
    logic [NUM_OUT-1:0] out_r;
    logic [NUM_OUT-1:0] out_nxt;
    generate
        for (genvar k = 0; k < NUM_OUT; k++)
        begin : g_out
            wire spc_func_t fsel = func_allowed(k, CFG.out_func[k]) ?
                                   CFG.out_func[k] : FUNC_GENERAL;
            assign out_nxt[k] = (fsel == FUNC_GENERAL) ? CFG.gp_out[k] : func_val[fsel];
        end
    endgenerate
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            out_r <= OUT_RST;
        else if (CE)
            out_r <= out_nxt;
    end
    assign {OUTPUT_SIX, OUTPUT_FIVE, OUTPUT_FOUR, OUTPUT_THREE, OUTPUT_TWO, OUTPUT_ONE} = out_r;

    // checks; frozen cycles are skipped by the clocking event
    default clocking cb @(posedge CORE_CLK iff CE);
    endclocking
    default disable iff (RST);

    a_inhibit_holds_pos: assert property (inhibit |=> $stable(CMD_POS))
        else $error("position moved while pulses inhibited");
    a_idle_no_move: assert property (!cnt_en |=> $stable(CMD_POS) && !CMD_STEP)
        else $error("position moved without a valid edge");
    a_step_exactly_one: assert property (cnt_en |=>
        (CMD_POS - $past(CMD_POS) == POS_W'(1)) || ($past(CMD_POS) - CMD_POS == POS_W'(1)))
        else $error("one edge did not move position by exactly one");
    a_step_strobe: assert property (cnt_en |=> CMD_STEP)
        else $error("counted edge gave no step strobe");
    a_stepdir_sense: assert property (cnt_en && CFG.fmt == FMT_STEP_DIR |=>
        CMD_DIR_CW == ($past(b_cur) ^ $past(CFG.dir_invert)))
        else $error("step direction does not follow direction input");
    a_cwccw_sense: assert property (cnt_en && CFG.fmt == FMT_CW_CCW && rise_b |=>
        CMD_DIR_CW == $past(CFG.dir_invert))
        else $error("second input pulse moved the wrong way");
    a_quad_lead_cw: assert property (pos_mode && !inhibit && CFG.fmt == FMT_QUAD &&
        !CFG.quad_invert && {a_prev_r, b_prev_r} == 2'h0 && {a_cur, b_cur} == 2'h2
        |=> CMD_POS == $past(CMD_POS) + POS_W'(1))
        else $error("first phase leading did not count clockwise");
    a_quad_double_skip: assert property (CFG.fmt == FMT_QUAD &&
        a_cur != a_prev_r && b_cur != b_prev_r |=> $stable(CMD_POS))
        else $error("double phase change was counted");
    a_gp_blocked: assert property (pos_mode |=> !GP_IN_ONE && !GP_IN_TWO)
        else $error("general input visible in position mode");
    a_alarm_out: assert property (CFG.out_func[0] == FUNC_ALARM |=>
        OUTPUT_ONE == $past(STAT.alarm))
        else $error("first output does not follow alarm");
    a_refused_general: assert property (CFG.out_func[0] == FUNC_BRAKE |=>
        OUTPUT_ONE == $past(CFG.gp_out[0]))
        else $error("refused function did not fall back to general use");
    a_brake_out: assert property (CFG.out_func[1] == FUNC_BRAKE |=>
        OUTPUT_TWO == $past(STAT.brake_on))
        else $error("second output does not follow brake");
    a_torque_out: assert property (CFG.out_func[2] == FUNC_TORQUE_REACH |=>
        OUTPUT_THREE == $past(STAT.torque_reached))
        else $error("third output does not follow torque reached");
    a_moving_out: assert property (CFG.out_func[3] == FUNC_MOVING |=>
        OUTPUT_FOUR == $past(moving))
        else $error("fourth output wrong for moving");
    a_velreach_out: assert property (CFG.out_func[3] == FUNC_VEL_REACH &&
        STAT.speed_act != STAT.speed_cmd |=> !OUTPUT_FOUR)
        else $error("velocity reached while speed differs");
    a_ready_out: assert property (CFG.out_func[4] == FUNC_SERVO_READY |=>
        OUTPUT_FIVE == ($past(STAT.drive_able) && !$past(STAT.alarm)))
        else $error("fifth output wrong for servo ready");
    a_inpos_out: assert property (CFG.out_func[5] == FUNC_IN_POS && !pos_mode |=>
        !OUTPUT_SIX)
        else $error("in position asserted outside position mode");
    a_tach_cause: assert property ($changed(tach_r) |-> $past(es[1]))
        else $error("tach toggled without encoder movement");
    a_feedback_repeat: assert property (##1 FEEDBACK_PHASE_A == $past(ENC_A) &&
        FEEDBACK_PHASE_B == $past(ENC_B) && FEEDBACK_INDEX == $past(ENC_Z) &&
        FEEDBACK_INDEX_OC_OE == $past(ENC_Z))
        else $error("encoder feedback not repeated");

    c_quad_step: cover property (CFG.fmt == FMT_QUAD && cnt_en);
    c_inhibited_edge: cover property (inhibit && fmt_valid);
    c_tach_toggle: cover property (tach_hit ##1 $changed(tach_r));
    c_cwccw_down: cover property (CFG.fmt == FMT_CW_CCW && cnt_en && !fmt_up);
    c_torque_servo_on: cover property (CFG.mode == MODE_TORQUE && CFG.out_func[4] == FUNC_SERVO_ON);

endmodule // spc_pulse_io

// >>> spc_pkg.sv
// shared constants, enums and carriers for the servo pulse command and status block
package spc_pkg;

    // core clock
    localparam int CLK_PERIOD_NS = 10;

    // highest pulse rates on the two command ports
    localparam int OPTO_MAX_KHZ = 500;
    localparam int FAST_MAX_KHZ = 2000;

    // shortest half period of a legal pulse train, in ns
    localparam int OPTO_HALF_NS = 1000000 / (2 * OPTO_MAX_KHZ);
    localparam int FAST_HALF_NS = 1000000 / (2 * FAST_MAX_KHZ);

    // half periods in whole cycles, rounded down so the filter never outlasts a pulse
    localparam int OPTO_HALF_CYC = OPTO_HALF_NS / CLK_PERIOD_NS;
    localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;

    // glitch filter length: a quarter of the shortest legal half period
    localparam int OPTO_FILT_CYC = OPTO_HALF_CYC / 4;
    localparam int FAST_FILT_CYC = FAST_HALF_CYC / 4;

    // filter channel layout
    localparam int CH_ONE = 0;
    localparam int CH_TWO = 1;
    localparam int CH_PULSE = 2;
    localparam int CH_SIGN = 3;
    localparam int CH_INHIBIT = 4;
    localparam int NUM_CH = 5;

    // number of status outputs
    localparam int NUM_OUT = 6;

    // reset values
    localparam logic [NUM_OUT-1:0] OUT_RST = 6'h00;
    localparam logic [2:0] ENC_RST = 3'h0;

    // operating modes
    typedef enum logic [1:0] {
        MODE_POSITION = 2'h0,
        MODE_VELOCITY = 2'h1,
        MODE_TORQUE = 2'h2
    } spc_mode_t;

    // pulse command formats
    typedef enum logic [1:0] {
        FMT_STEP_DIR = 2'h0,
        FMT_CW_CCW = 2'h1,
        FMT_QUAD = 2'h2
    } spc_fmt_t;

    // status output functions
    typedef enum logic [3:0] {
        FUNC_GENERAL = 4'h0,
        FUNC_ALARM = 4'h1,
        FUNC_BRAKE = 4'h2,
        FUNC_TORQUE_REACH = 4'h3,
        FUNC_MOVING = 4'h4,
        FUNC_VEL_REACH = 4'h5,
        FUNC_SERVO_READY = 4'h6,
        FUNC_SERVO_ON = 4'h7,
        FUNC_IN_POS = 4'h8,
        FUNC_TACH = 4'h9
    } spc_func_t;

    // configuration set by the drive's parameter store
    typedef struct packed {
        spc_mode_t mode;
        spc_fmt_t fmt;
        logic port_fast;
        logic dir_invert;
        logic quad_invert;
        spc_func_t [NUM_OUT-1:0] out_func;
        logic [NUM_OUT-1:0] gp_out;
        logic [15:0] move_thresh;
        logic [15:0] inpos_thresh;
        logic [15:0] ripple_band;
        logic [15:0] tach_div;
    } spc_cfg_t;

    // drive state reported by the servo loop
    typedef struct packed {
        logic alarm;
        logic brake_on;
        logic torque_reached;
        logic drive_able;
        logic servo_on;
        logic in_position;
        logic [15:0] follow_err;
        logic [15:0] pos_err;
        logic signed [15:0] speed_act;
        logic signed [15:0] speed_cmd;
        logic [15:0] ripple;
    } spc_stat_t;

endpackage

// >>> spc_host_model.sv
// host-side pulse source that drives one command port at a legal rate
`timescale 1ns/100ps

module spc_host_model (
    // clock
    input wire logic core_clk,
    // opto pulse pair
    output logic opto_one,
    output logic opto_two,
    // fast differential pair
    output logic fast_pulse,
    output logic fast_sign
);
    import spc_pkg::*;

    // both ports off at time zero
    initial
    begin
        {opto_one, opto_two, fast_pulse, fast_sign} = 4'h0;
    end

    // set one pair and park the other off; extra cycles model a slow host
    task automatic hold(input logic fast, input logic a, input logic b, input int extra = 0);
        @(negedge core_clk);
        opto_one <= a & ~fast;
        opto_two <= b & ~fast;
        fast_pulse <= a & fast;
        fast_sign <= b & fast;
        // a full half period per level keeps the train at or under the top rate
        repeat ((fast ? FAST_HALF_CYC : OPTO_HALF_CYC) + extra) @(negedge core_clk);
    endtask
endmodule // spc_host_model

// >>> spc_pulse_io_tb.sv
// self-checking bench for the pulse command decoder and status outputs
`timescale 1ns/100ps

module spc_pulse_io_tb;
    import spc_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic inhibit = 1'b0;
    logic enc_a = 1'b0;
    logic enc_b = 1'b0;
    logic enc_z = 1'b0;
    spc_cfg_t cfg = '0;
    spc_stat_t stat = '0;
    logic opto_one, opto_two, fast_pulse, fast_sign;
    logic signed [31:0] cmd_pos;
    logic cmd_step, cmd_dir_cw, gp_one, gp_two, oc_o, oc_oe;
    logic [5:0] outs;
    logic [2:0] fb;
    logic [31:0] base = '0;
    logic [1:0] gray [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int bad_count = 0;
    int check_count = 0;
    int steps = 0;
    int base_steps = 0;
    int cycles = 0;
    int qi = 0;

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    // count step strobes; the ceiling is about fourteen times the expected run
    always @(posedge core_clk)
    begin
        if (cmd_step === 1'b1)
            steps++;
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            stop_test();
        end
    end

    spc_pulse_io dut_u (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .CFG(cfg), .STAT(stat),
        .FAST_INPUT_ONE(opto_one), .FAST_INPUT_TWO(opto_two), .FAST_PULSE_IN(fast_pulse),
        .FAST_SIGN_IN(fast_sign), .PULSE_INHIBIT_INPUT(inhibit), .CMD_POS(cmd_pos),
        .CMD_STEP(cmd_step), .CMD_DIR_CW(cmd_dir_cw), .GP_IN_ONE(gp_one), .GP_IN_TWO(gp_two),
        .ENC_A(enc_a), .ENC_B(enc_b), .ENC_Z(enc_z), .OUTPUT_ONE(outs[0]), .OUTPUT_TWO(outs[1]),
        .OUTPUT_THREE(outs[2]), .OUTPUT_FOUR(outs[3]), .OUTPUT_FIVE(outs[4]),
        .OUTPUT_SIX(outs[5]), .FEEDBACK_PHASE_A(fb[2]), .FEEDBACK_PHASE_B(fb[1]),
        .FEEDBACK_INDEX(fb[0]), .FEEDBACK_INDEX_OC_O(oc_o), .FEEDBACK_INDEX_OC_OE(oc_oe));

    spc_host_model host_u (.core_clk(core_clk), .opto_one(opto_one), .opto_two(opto_two),
        .fast_pulse(fast_pulse), .fast_sign(fast_sign));

    // verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // net travel since the last call, and one strobe per counted edge
    task automatic moved(input string what, input int d);
        repeat (3) @(negedge core_clk);
        base = base + d;
        base_steps = base_steps + (d < 0 ? -d : d);
        chk(what, base, cmd_pos);
        chk({what, " strobes"}, base_steps, steps);
    endtask

    task automatic steps_dir(input logic fast, input logic dir, input int n);
        host_u.hold(fast, 1'b0, dir);
        repeat (n)
        begin
            host_u.hold(fast, 1'b1, dir);
            host_u.hold(fast, 1'b0, dir);
        end
        host_u.hold(fast, 1'b0, 1'b0);
    endtask

    task automatic quad(input logic fwd, input int n);
        repeat (n)
        begin
            qi = (qi + (fwd ? 1 : 3)) % 4;
            host_u.hold(1'b1, gray[qi][1], gray[qi][0]);
        end
    endtask

    task automatic t_step_dir();
        cfg.port_fast = 1'b1;
        steps_dir(1'b1, 1'b1, 3);
        moved("fast step up", 3);
        chk("dir cw", 1, cmd_dir_cw);
        steps_dir(1'b1, 1'b0, 2);
        moved("fast step down", -2);
        cfg.dir_invert = 1'b1;
        steps_dir(1'b1, 1'b1, 2);
        moved("inverted step", -2);
        cfg.dir_invert = 1'b0;
        cfg.port_fast = 1'b0;
        steps_dir(1'b0, 1'b1, 2);
        moved("opto step up", 2);
        steps_dir(1'b1, 1'b1, 1);
        moved("unselected port", 0);
    endtask

    task automatic t_cw_quad();
        cfg.port_fast = 1'b1;
        cfg.fmt = FMT_CW_CCW;
        host_u.hold(1'b1, 1'b1, 1'b0, 3);
        host_u.hold(1'b1, 1'b0, 1'b0, 3);
        moved("cw pulse", 1);
        host_u.hold(1'b1, 1'b0, 1'b1);
        host_u.hold(1'b1, 1'b0, 1'b0);
        moved("ccw pulse", -1);
        cfg.fmt = FMT_QUAD;
        quad(1'b1, 8);
        moved("one leads two", 8);
        quad(1'b0, 4);
        moved("two leads one", -4);
        cfg.quad_invert = 1'b1;
        quad(1'b1, 4);
        moved("inverted quadrature", -4);
        cfg.quad_invert = 1'b0;
        host_u.hold(1'b1, 1'b1, 1'b1);
        host_u.hold(1'b1, 1'b0, 1'b0);
        moved("both phases changed", 0);
    endtask

    // inhibit filter needs sync plus 25 cycles before it takes hold
    task automatic t_inhibit_gp();
        cfg.fmt = FMT_STEP_DIR;
        inhibit = 1'b1;
        repeat (30) @(negedge core_clk);
        steps_dir(1'b1, 1'b1, 2);
        moved("inhibited pulses", 0);
        inhibit = 1'b0;
        repeat (30) @(negedge core_clk);
        steps_dir(1'b1, 1'b1, 1);
        moved("inhibit released", 1);
        cfg.port_fast = 1'b0;
        cfg.mode = MODE_VELOCITY;
        steps_dir(1'b0, 1'b1, 1);
        moved("velocity mode pulses", 0);
        host_u.hold(1'b0, 1'b1, 1'b0);
        chk("gp inputs", 2'h2, {gp_one, gp_two});
        cfg.mode = MODE_POSITION;
        repeat (3) @(negedge core_clk);
        chk("gp in position mode", 0, gp_one);
        host_u.hold(1'b0, 1'b0, 1'b0);
    endtask

    task automatic out_is(input string what, input logic [5:0] exp);
        repeat (2) @(negedge core_clk);
        chk(what, exp, outs);
    endtask

    task automatic t_outputs();
        cfg.out_func[0] = FUNC_ALARM;
        cfg.out_func[1] = FUNC_BRAKE;
        cfg.out_func[2] = FUNC_TORQUE_REACH;
        cfg.out_func[3] = FUNC_MOVING;
        cfg.out_func[4] = FUNC_SERVO_READY;
        cfg.out_func[5] = FUNC_IN_POS;
        cfg.move_thresh = 16'h0005;
        cfg.inpos_thresh = 16'h0003;
        cfg.ripple_band = 16'h0004;
        stat = '{drive_able: 1'b1, in_position: 1'b1, follow_err: 16'h0004,
            pos_err: 16'h0002, default: '0};
        out_is("quiet drive", 6'h38);
        {stat.alarm, stat.brake_on, stat.torque_reached} = 3'h7;
        out_is("alarm brake torque", 6'h2f);
        {stat.alarm, stat.brake_on, stat.torque_reached} = 3'h0;
        stat.follow_err = 16'h0005;
        stat.pos_err = 16'h0003;
        out_is("errors at threshold", 6'h10);
        cfg.mode = MODE_VELOCITY;
        cfg.out_func[3] = FUNC_VEL_REACH;
        stat.speed_act = 16'sh0064;
        stat.speed_cmd = 16'sh0064;
        stat.ripple = 16'h0004;
        out_is("velocity reached", 6'h18);
        stat.ripple = 16'h0005;
        out_is("ripple too large", 6'h10);
        stat.ripple = 16'h0004;
        cfg.out_func[0] = FUNC_BRAKE;
        cfg.out_func[1] = FUNC_GENERAL;
        cfg.gp_out = 6'h02;
        stat.brake_on = 1'b1;
        out_is("general and refused", 6'h1a);
        cfg.mode = MODE_TORQUE;
        cfg.out_func[4] = FUNC_SERVO_ON;
        out_is("torque mode servo on", 6'h0a);
    endtask

    task automatic t_encoder();
        int tg;
        logic last;
        cfg.out_func[5] = FUNC_TACH;
        cfg.tach_div = 16'h0002;
        {enc_a, enc_b, enc_z} = 3'h5;
        repeat (3) @(negedge core_clk);
        chk("encoder repeat", 5'h15, {fb, oc_o, oc_oe});
        tg = 0;
        last = outs[5];
        for (int i = 0; i < 4; i++)
        begin
            if (i[0])
                enc_a = ~enc_a;
            else
                enc_b = ~enc_b;
            repeat (3) @(negedge core_clk);
            if (outs[5] !== last)
                tg++;
            last = outs[5];
        end
        chk("tach toggles", 2, tg);
        // enable low must freeze the repeat path
        ce = 1'b0;
        enc_a = ~enc_a;
        repeat (3) @(negedge core_clk);
        chk("frozen feedback", 3'h5, fb);
        ce = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("feedback after freeze", 3'h1, fb);
    endtask

    // reset, then each scenario in turn
    initial
    begin
        repeat (20) @(negedge core_clk);
        chk("outputs in reset", 0, {outs, fb, cmd_step, cmd_pos[0]});
        rst = 1'b0;
        t_step_dir();
        t_cw_quad();
        t_inhibit_gp();
        t_outputs();
        t_encoder();
        stop_test();
    end
endmodule // spc_pulse_io_tb
